// ==== drs_copy.sv ====
// Span copy engine: APB register slave, command decode, source read master, frame writer.
// Assumes the read master and frame write ports are on pclk and answer with one-cycle acks.
//
// The placing of the registers and the APB slave port were decided locally.
`default_nettype none
module drs_copy (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              cmd_valid,
	input  wire drs_pkg::drs_cmd_t cmd,
	output logic                   cmd_ready,
	output logic                   rd_req,
	output logic [31:0]            rd_addr,
	input  wire logic              rd_ack,
	input  wire logic [31:0]       rd_data,
	output drs_pkg::drs_fbw_t      fbw,
	input  wire logic              fbw_ack
);
	// *****************************
	// Registers
	// *****************************
	logic [31:0] dma_base_address_reg_q;
	logic [31:0] pixel_shift_reg_q;
	logic [31:0] raster_operation_reg_q;
	logic [31:0] global_mode_reg_q;
	logic [31:0] deep_config_reg_q;
	logic [31:0] scaled_copy_control_reg_q;
	logic [31:0] bresenham_one_reg_q;
	logic [31:0] dither_row_reg_q;
	logic [31:0] rdata_d;
	logic        hit_d;
	logic        wr_en;
	drs_pkg::drs_state_t st_q;
	logic        scaled_q;
	logic [11:0] n_q;
	logic [11:0] idx_q;
	logic [15:0] masks_q;
	logic [3:0]  rep_q;
	logic [31:0] src_start_q;
	logic [31:0] res_q;
	logic        span_done;
	logic        take;
	logic        last;
	logic [10:0] cnt_raw;
	logic [10:0] cnt_eff;
	logic [31:0] scaled_src;
	logic [63:0] rot_in;
	logic [31:0] rot_out;
	logic [31:0] swapped;
	logic [31:0] flush_out;
	logic [3:0]  emask;
	logic [3:0]  bmask;
	logic [1:0]  shift;
	logic [1:0]  spix;
	logic [1:0]  epix;
	logic [31:0] inc_ext;

	assign wr_en = psel && penable && pready && pwrite;
	assign take = cmd_valid && cmd_ready;
	assign last = (idx_q == (n_q - 12'h001));
	assign shift = pixel_shift_reg_q[drs_pkg::SHIFT_W-1:0];
	assign bmask = raster_operation_reg_q[drs_pkg::BMASK_LSB +: 4];
	assign spix = scaled_copy_control_reg_q[drs_pkg::SPIX_LSB +: 2];
	assign epix = scaled_copy_control_reg_q[drs_pkg::EPIX_LSB +: 2];
	assign inc_ext = {{16{bresenham_one_reg_q[31]}}, bresenham_one_reg_q[drs_pkg::INC_LSB +: 16]};
	assign span_done = (st_q == drs_pkg::DRS_WRITE) && fbw_ack && last;

	// Command decode for both modes
	always_comb begin
		cnt_raw = cmd.data[drs_pkg::CNT_LSB +: drs_pkg::CNT_W];
		cnt_eff = cnt_raw;
		// Scaled spans cap at 1K Dwords; the count field itself allows 2K
		if ((global_mode_reg_q[drs_pkg::MODE_LSB +: drs_pkg::MODE_W] == drs_pkg::MODE_SCALED)
			&& (cnt_raw > drs_pkg::SCALED_MAX_CNT)) begin
			cnt_eff = drs_pkg::SCALED_MAX_CNT;
		end
		scaled_src = dma_base_address_reg_q;
		scaled_src[drs_pkg::BASE_MID_LSB +: drs_pkg::MID_W] =
			cmd.data[drs_pkg::MID_LSB +: drs_pkg::MID_W];
	end

	// Residue rotation; shift 0 passes the source through untouched
	always_comb begin
		rot_in = {rd_data, res_q};
		rot_out = 32'h0000_0000;
		flush_out = 32'h0000_0000;
		unique case (shift)
			2'h0: rot_out = rot_in[63:32];
			2'h1: begin
				rot_out = rot_in[55:24];
				flush_out = {24'h00_0000, res_q[31:24]};
			end
			2'h2: begin
				rot_out = rot_in[47:16];
				flush_out = {16'h0000, res_q[31:16]};
			end
			2'h3: begin
				rot_out = rot_in[39:8];
				flush_out = {8'h00, res_q[31:8]};
			end
		endcase
		// Swap bytes inside each pixel, per source format
		swapped = rot_out;
		if (deep_config_reg_q[drs_pkg::SWAP_BIT]) begin
			if (global_mode_reg_q[drs_pkg::FMT_LSB +: drs_pkg::FMT_W] == drs_pkg::FMT_16BPP) begin
				swapped = {rot_out[23:16], rot_out[31:24], rot_out[7:0], rot_out[15:8]};
			end else if (global_mode_reg_q[drs_pkg::FMT_LSB +: drs_pkg::FMT_W]
				== drs_pkg::FMT_32BPP) begin
				swapped = {rot_out[7:0], rot_out[15:8], rot_out[23:16], rot_out[31:24]};
			end
		end
	end

	// Edge mask for the Dword now in hand; interior Dwords go whole in DMA copy, scaled ones take the draw enables
	always_comb begin
		emask = drs_pkg::MASK_ALL;
		if (scaled_q) begin
			if (idx_q == 12'h000) emask = emask & (drs_pkg::MASK_ALL << spix);
			if (last) emask = emask & (drs_pkg::MASK_ALL >> (2'h3 - epix));
			emask = emask & scaled_copy_control_reg_q[drs_pkg::DRAW_LSB +: 4];
		end else begin
			// Short spans drop left masks that would overlap the right edge
			if ((idx_q == 12'h000) && (n_q >= 12'h002)) begin
				emask = emask & masks_q[drs_pkg::ML0_LSB +: 4];
			end
			if ((idx_q == 12'h001) && (n_q >= 12'h003)) begin
				emask = emask & masks_q[drs_pkg::ML1_LSB +: 4];
			end
			if (last) begin
				emask = emask & masks_q[drs_pkg::MR0_LSB +: 4];
			end
		end
	end

	// *****************************
	// APB slave
	// *****************************
	// Read mux; unmapped offsets answer zero with an error
	always_comb begin
		hit_d = 1'b1;
		unique case (paddr)
			drs_pkg::ADDR_DMA_BASE: rdata_d = dma_base_address_reg_q;
			drs_pkg::ADDR_PIX_SHIFT: rdata_d = pixel_shift_reg_q;
			drs_pkg::ADDR_RASTER_OP: rdata_d = raster_operation_reg_q;
			drs_pkg::ADDR_GLOB_MODE: rdata_d = global_mode_reg_q;
			drs_pkg::ADDR_DEEP_CFG: rdata_d = deep_config_reg_q;
			drs_pkg::ADDR_SCALED_CTL: rdata_d = scaled_copy_control_reg_q;
			drs_pkg::ADDR_BRES_ONE: rdata_d = bresenham_one_reg_q;
			drs_pkg::ADDR_DITHER_ROW: rdata_d = dither_row_reg_q;
			drs_pkg::ADDR_STATUS: rdata_d = {n_q, idx_q, 6'h00, st_q};
			default: begin
				rdata_d = 32'h0000_0000;
				hit_d = 1'b0;
			end
		endcase
	end

	// Answer in the first access cycle; pready is registered from setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit_d;
			prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
		end
	end

	// Register writes; the dither row also steps once per finished scaled span
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_base_address_reg_q <= 32'h0000_0000;
			pixel_shift_reg_q <= 32'h0000_0000;
			raster_operation_reg_q <= 32'h0000_0000;
			global_mode_reg_q <= 32'h0000_0000;
			deep_config_reg_q <= 32'h0000_0000;
			scaled_copy_control_reg_q <= 32'h0000_0000;
			bresenham_one_reg_q <= 32'h0000_0000;
			dither_row_reg_q <= 32'h0000_0000;
		end else begin
			if (wr_en && paddr == drs_pkg::ADDR_DMA_BASE) dma_base_address_reg_q <= pwdata;
			if (wr_en && paddr == drs_pkg::ADDR_PIX_SHIFT) pixel_shift_reg_q <= {28'h000_0000, pwdata[3:0]};
			if (wr_en && paddr == drs_pkg::ADDR_RASTER_OP) raster_operation_reg_q <= pwdata;
			if (wr_en && paddr == drs_pkg::ADDR_GLOB_MODE) global_mode_reg_q <= pwdata;
			if (wr_en && paddr == drs_pkg::ADDR_DEEP_CFG) deep_config_reg_q <= pwdata;
			if (wr_en && paddr == drs_pkg::ADDR_SCALED_CTL) scaled_copy_control_reg_q <= pwdata;
			if (wr_en && paddr == drs_pkg::ADDR_BRES_ONE) bresenham_one_reg_q <= pwdata;
			// Hardware step wins over a software write in the same cycle
			if (span_done && scaled_q) begin
				dither_row_reg_q[drs_pkg::DROW_LSB +: drs_pkg::DROW_W] <=
					dither_row_reg_q[drs_pkg::DROW_LSB +: drs_pkg::DROW_W] + 5'h01;
			end else if (wr_en && paddr == drs_pkg::ADDR_DITHER_ROW) begin
				dither_row_reg_q <= pwdata;
			end
		end
	end

	// *****************************
	// Copy engine
	// *****************************
	// One read, one write per Dword; no copy buffer in between
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= drs_pkg::DRS_IDLE;
			cmd_ready <= 1'b1;
			rd_req <= 1'b0;
			rd_addr <= 32'h0000_0000;
			fbw <= '0;
			scaled_q <= 1'b0;
			n_q <= 12'h000;
			idx_q <= 12'h000;
			masks_q <= 16'h0000;
			rep_q <= 4'h0;
			src_start_q <= 32'h0000_0000;
			res_q <= 32'h0000_0000;
		end else begin
			unique case (st_q)
				drs_pkg::DRS_IDLE: begin
					if (take) begin
						scaled_q <= (global_mode_reg_q[drs_pkg::MODE_LSB +: drs_pkg::MODE_W]
							== drs_pkg::MODE_SCALED);
						n_q <= {1'b0, cnt_eff} + 12'h001;
						idx_q <= 12'h000;
						masks_q <= cmd.data[15:0];
						rep_q <= cmd.data[drs_pkg::REP_LSB +: drs_pkg::REP_W];
						res_q <= 32'h0000_0000;
						fbw.addr <= cmd.addr;
						if (global_mode_reg_q[drs_pkg::MODE_LSB +: drs_pkg::MODE_W]
							== drs_pkg::MODE_SCALED) begin
							rd_addr <= scaled_src;
							src_start_q <= scaled_src;
						end else begin
							rd_addr <= dma_base_address_reg_q;
							src_start_q <= dma_base_address_reg_q;
						end
						rd_req <= 1'b1;
						cmd_ready <= 1'b0;
						st_q <= drs_pkg::DRS_READ;
					end
				end
				drs_pkg::DRS_READ: begin
					if (rd_ack) begin
						rd_req <= 1'b0;
						res_q <= rd_data;
						fbw.valid <= 1'b1;
						fbw.data <= swapped;
						fbw.mask <= emask & bmask;
						fbw.rop <= raster_operation_reg_q[drs_pkg::ROP_LSB +: drs_pkg::ROP_W];
						fbw.fmt <= raster_operation_reg_q[drs_pkg::FMT_LSB +: drs_pkg::FMT_W];
						st_q <= drs_pkg::DRS_WRITE;
					end
				end
				drs_pkg::DRS_WRITE: begin
					if (fbw_ack) begin
						idx_q <= idx_q + 12'h001;
						fbw.valid <= 1'b0;
						fbw.addr <= fbw.addr + drs_pkg::DWORD_BYTES;
						if (!last) begin
							rd_addr <= rd_addr + drs_pkg::DWORD_BYTES;
							rd_req <= 1'b1;
							st_q <= drs_pkg::DRS_READ;
						end else if (!scaled_q) begin
							// Residue goes to the next address under right mask 1
							fbw.valid <= 1'b1;
							fbw.data <= flush_out;
							fbw.mask <= masks_q[drs_pkg::MR1_LSB +: 4] & bmask;
							st_q <= drs_pkg::DRS_FLUSH;
						end else if (rep_q != 4'h0) begin
							// Next destination span re-reads the same source
							rep_q <= rep_q - 4'h1;
							fbw.addr <= fbw.addr + inc_ext;
							idx_q <= 12'h000;
							res_q <= 32'h0000_0000;
							rd_addr <= src_start_q;
							rd_req <= 1'b1;
							st_q <= drs_pkg::DRS_READ;
						end else begin
							cmd_ready <= 1'b1;
							st_q <= drs_pkg::DRS_IDLE;
						end
					end
				end
				drs_pkg::DRS_FLUSH: begin
					if (fbw_ack) begin
						fbw.valid <= 1'b0;
						fbw.addr <= fbw.addr + drs_pkg::DWORD_BYTES;
						cmd_ready <= 1'b1;
						st_q <= drs_pkg::DRS_IDLE;
					end
				end
			endcase
		end
	end

	// *****************************
	// Checks
	// *****************************
	logic [11:0] rd_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_seen_q <= 12'h000;
		end else if (take) begin
			rd_seen_q <= 12'h000;
		end else if (st_q == drs_pkg::DRS_READ && rd_ack) begin
			rd_seen_q <= rd_seen_q + 12'h001;
		end
	end

	default clocking drs_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn); // Checks sleep while reset is held
	property p_read_total;
		(st_q == drs_pkg::DRS_FLUSH && fbw_ack) |-> (rd_seen_q == n_q);
	endproperty
	a_read_total: assert property (p_read_total) else $error("read total wrong");
	property p_dma_start;
		(take && global_mode_reg_q[3:0] == drs_pkg::MODE_DMA_COPY)
			|=> (rd_req && rd_addr == $past(dma_base_address_reg_q) && fbw.addr == $past(cmd.addr));
	endproperty
	a_dma_start: assert property (p_dma_start) else $error("bad read start");
	property p_scaled_start;
		(take && global_mode_reg_q[3:0] == drs_pkg::MODE_SCALED)
			|=> (rd_addr[22:7] == $past(cmd.data[15:0]));
	endproperty
	a_scaled_start: assert property (p_scaled_start) else $error("bad middle address");
	property p_first_mask;
		(st_q == drs_pkg::DRS_READ && rd_ack && !scaled_q && idx_q == 12'h000 && n_q >= 12'h002)
			|=> (fbw.mask == (masks_q[3:0] & bmask));
	endproperty
	a_first_mask: assert property (p_first_mask) else $error("first mask wrong");
	property p_single_mask;
		(st_q == drs_pkg::DRS_READ && rd_ack && !scaled_q && n_q == 12'h001)
			|=> (fbw.mask == (masks_q[11:8] & bmask));
	endproperty
	a_single_mask: assert property (p_single_mask) else $error("short mask wrong");
	property p_flush;
		span_done && !scaled_q
			|=> (st_q == drs_pkg::DRS_FLUSH && fbw.valid
				&& fbw.addr == $past(fbw.addr) + 32'h0000_0004
				&& fbw.mask == (masks_q[15:12] & bmask));
	endproperty
	a_flush: assert property (p_flush) else $error("residue write wrong");
	property p_rop;
		(st_q == drs_pkg::DRS_READ && rd_ack)
			|=> (fbw.rop == raster_operation_reg_q[3:0] && fbw.fmt == raster_operation_reg_q[10:8]);
	endproperty
	a_rop: assert property (p_rop) else $error("raster op not carried");
	property p_busy;
		(st_q != drs_pkg::DRS_IDLE) |-> !cmd_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("command taken while busy");
	property p_dither_step;
		(span_done && scaled_q)
			|=> (dither_row_reg_q[31:27] == $past(dither_row_reg_q[31:27]) + 5'h01);
	endproperty
	a_dither_step: assert property (p_dither_step) else $error("dither row not stepped");
	c_dma_flush: cover property (st_q == drs_pkg::DRS_FLUSH && fbw_ack);
	c_scaled_repeat: cover property (span_done && scaled_q && rep_q != 4'h0);
	c_long_span: cover property (st_q == drs_pkg::DRS_WRITE && idx_q == 12'h003);
endmodule
`default_nettype wire

// ==== drs_host_mem.sv ====
// Model of the host bus memory and the frame store behind the span copy engine.
// Assumes requests on pclk that hold until acknowledged; lag sets answer delay.
`default_nettype none
module drs_host_mem (
	input  wire logic              pclk,
	input  wire logic              rd_req,
	input  wire logic [31:0]       rd_addr,
	output logic                   rd_ack,
	output logic [31:0]            rd_data,
	input  wire drs_pkg::drs_fbw_t fbw,
	output logic                   fbw_ack,
	input  wire logic [3:0]        lag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] rd_cnt = 4'h0;
	logic [3:0] wr_cnt = 4'h0;
	initial begin
		rd_ack = 1'b0;
		fbw_ack = 1'b0;
		rd_data = 32'h0;
	end
	// Source reads; data toggles when not valid so stale values never match
	always @(posedge pclk) begin
		if (rd_ack || !rd_req) begin
			rd_ack <= 1'b0;
			rd_data <= ~rd_data;
			rd_cnt <= 4'h0;
		end else if (rd_cnt < lag) begin
			rd_cnt <= rd_cnt + 4'h1;
			rd_data <= ~rd_data;
		end else begin
			rd_ack <= 1'b1;
			rd_data <= {~rd_addr[15:0], rd_addr[15:0]};
		end
	end
	// Frame store accepts each write after the same lag
	always @(posedge pclk) begin
		if (fbw_ack || !fbw.valid) begin
			fbw_ack <= 1'b0;
			wr_cnt <= 4'h0;
		end else if (wr_cnt < lag)
			wr_cnt <= wr_cnt + 4'h1;
		else
			fbw_ack <= 1'b1;
	end
endmodule
`default_nettype wire

// ==== drs_pkg.sv ====
// Constants, carriers and states for the DMA-read span copy engine.
// Assumes an APB master for set-up and a host-side command port for frame buffer writes.
// Notes on behaviour
// - Frame buffer write starts one span copy
// - Command bits 26:16 hold read count minus one
// - Command nibbles: right1, right0, left1, left0 masks
// - Master reads from DMA base, writes destination
// - First, second, last Dwords masked; others whole
// - Residue written after last, right1 masked
// - Every write carries raster op and byte mask
// - Source and residue rotated by pixel shift
// - No copy buffer; writes go straight out
// - Only edge masks, no per-pixel masking
// - Byte swap within pixel only when enabled
// - Short spans ignore some left masks
// - Destination and source formats from registers
// - Scaled copy: one span up to 1K
// - Scaled command: repeat, count, middle address
// - Repeat spans, address increment, dither row step
// - Start, end pixel and draw enables from control
// - Middle address replaces base bits 22:7
`default_nettype none
package drs_pkg;
	// *****************************
	// Register map (byte addresses)
	// *****************************
	localparam logic [7:0] ADDR_DMA_BASE = 8'h00;
	localparam logic [7:0] ADDR_PIX_SHIFT = 8'h04;
	localparam logic [7:0] ADDR_RASTER_OP = 8'h08;
	localparam logic [7:0] ADDR_GLOB_MODE = 8'h0C;
	localparam logic [7:0] ADDR_DEEP_CFG = 8'h10;
	localparam logic [7:0] ADDR_SCALED_CTL = 8'h14;
	localparam logic [7:0] ADDR_BRES_ONE = 8'h18;
	localparam logic [7:0] ADDR_DITHER_ROW = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// *****************************
	// Field layouts
	// *****************************
	localparam int CNT_LSB = 16;
	localparam int CNT_W = 11;
	localparam int REP_LSB = 28;
	localparam int REP_W = 4;
	localparam int MID_LSB = 0;
	localparam int MID_W = 16;
	localparam int BASE_MID_LSB = 7;
	localparam int ML0_LSB = 0;
	localparam int ML1_LSB = 4;
	localparam int MR0_LSB = 8;
	localparam int MR1_LSB = 12;
	localparam int ROP_LSB = 0;
	localparam int ROP_W = 4;
	localparam int BMASK_LSB = 16;
	localparam int FMT_LSB = 8;
	localparam int FMT_W = 3;
	localparam int SWAP_BIT = 21;
	localparam int SPIX_LSB = 0;
	localparam int EPIX_LSB = 2;
	localparam int DRAW_LSB = 4;
	localparam int INC_LSB = 16;
	localparam int DROW_LSB = 27;
	localparam int DROW_W = 5;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int SHIFT_W = 2;
	// *****************************
	// Codes and limits
	// *****************************
	localparam logic [3:0] MODE_DMA_COPY = 4'h1;
	localparam logic [3:0] MODE_SCALED = 4'h2;
	localparam logic [2:0] FMT_16BPP = 3'h1;
	localparam logic [2:0] FMT_32BPP = 3'h2;
	localparam logic [10:0] SCALED_MAX_CNT = 11'h3FF;
	localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
	localparam logic [3:0] MASK_ALL = 4'hF;

	typedef enum logic [1:0] {
		DRS_IDLE = 2'b00,
		DRS_READ = 2'b01,
		DRS_WRITE = 2'b10,
		DRS_FLUSH = 2'b11
	} drs_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} drs_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  mask;
		logic [3:0]  rop;
		logic [2:0]  fmt;
	} drs_fbw_t;
endpackage
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the span copy engine.
// Assumes the host memory model answers each read with data built from its address, {~addr, addr}.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'hA5A5_A5C4;
	localparam logic [31:0] DEST = 32'h0001_0100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic cmd_valid, cmd_ready, rd_req, rd_ack, fbw_ack;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_addr, rd_data;
	logic [3:0] lag;
	drs_pkg::drs_cmd_t cmd;
	drs_pkg::drs_fbw_t fbw;
	drs_pkg::drs_fbw_t wq[$];
	logic [31:0] ra[$];
	int failures, n_tests, cyc;
	drs_copy dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
		.rd_data(rd_data), .fbw(fbw), .fbw_ack(fbw_ack));
	drs_host_mem mem (.pclk(pclk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
		.rd_data(rd_data), .fbw(fbw), .fbw_ack(fbw_ack), .lag(lag));
	// *****************************
	// Clock, monitor, timeout
	// *****************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (fbw.valid === 1'b1 && fbw_ack === 1'b1) wq.push_back(fbw);
		if (rd_req === 1'b1 && rd_ack === 1'b1) ra.push_back(rd_addr);
		cyc++;
		if (cyc == 60000) begin
			failures++;
			stop_test();
		end
	end
	// *****************************
	// Shared tasks
	// *****************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	// Issue a frame buffer write, then wait for nw writes and idle
	task automatic run_cmd(input logic [31:0] data, input int nw);
		wq.delete();
		ra.delete();
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd <= {DEST, data};
		do @(posedge pclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		@(posedge pclk);
		chk("busy", 32'h0, {31'h0, cmd_ready});
		for (int i = 0; i < 20000 && !(wq.size() >= nw && cmd_ready === 1'b1); i++)
			@(posedge pclk);
		chk("writes", nw, wq.size());
	endtask
	function automatic logic [31:0] src(input logic [31:0] a);
		return {~a[15:0], a[15:0]};
	endfunction
	// DMA copy of n Dwords with pixel shift s and edge masks m; sw picks a 32 bpp source
	task automatic run_dma(input int n, input logic [1:0] s, input logic [15:0] m,
			input logic [3:0] lg, input logic sw);
		logic [31:0] pv, cur, d;
		logic [3:0] em;
		lag <= lg;
		wr(drs_pkg::ADDR_PIX_SHIFT, {30'h0, s});
		wr(drs_pkg::ADDR_RASTER_OP, 32'h000B_0306);
		wr(drs_pkg::ADDR_DMA_BASE, BASE);
		wr(drs_pkg::ADDR_GLOB_MODE, sw ? 32'h0000_0201 : 32'h0000_0001);
		run_cmd({5'h0, 11'(n - 1), m}, n + 1);
		chk("reads", n, ra.size());
		chk("rd_addr", BASE + 32'(4 * (n - 1)), ra[n - 1]);
		pv = 32'h0;
		for (int i = 0; i <= n; i++) begin
			cur = (i < n) ? src(BASE + 32'(4 * i)) : 32'h0;
			em = (i == n) ? m[15:12] : (i == n - 1) ? m[11:8] : (i == 0) ? m[3:0] :
				(i == 1 && n > 2) ? m[7:4] : 4'hF;
			// A 32 bpp source with swap enabled reverses all four bytes of each pixel
			d = 32'({cur, pv} >> (8 * (4 - s)));
			if (sw) d = {d[7:0], d[15:8], d[23:16], d[31:24]};
			chk("addr", DEST + 32'(4 * i), wq[i].addr);
			chk("data", d, wq[i].data);
			chk("mask", {28'h0, em & 4'hB}, {28'h0, wq[i].mask});
			chk("rop", {20'h0, 3'h3, 5'h0, 4'h6}, {20'h0, wq[i].fmt, 5'h0, wq[i].rop});
			pv = cur;
		end
	endtask
	// *****************************
	// Scenarios
	// *****************************
	task automatic t_regs;
		logic [31:0] q;
		logic e;
		chk("idle", 32'h1, {31'h0, cmd_ready & ~rd_req});
		wr(drs_pkg::ADDR_DMA_BASE, 32'h1234_5678);
		apb(1'b0, drs_pkg::ADDR_DMA_BASE, 32'h0, q, e);
		chk("base", 32'h1234_5678, q);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
		chk("wr_err", 32'h1, {31'h0, e});
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("rd_err", 32'h1, {31'h0, e});
		chk("rd_zero", 32'h0, q);
		wr(drs_pkg::ADDR_DEEP_CFG, 32'h0020_0000);
	endtask
	// Primed and flushed span, slow partner
	task automatic t_long;
		run_dma(5, 2'h1, 16'h3FE0, 4'h2, 1'b0);
	endtask
	task automatic t_two;
		run_dma(2, 2'h3, 16'h07FC, 4'h0, 1'b0);
	endtask
	// Single Dword from a 32 bpp source with the swap bit set earlier
	task automatic t_one;
		run_dma(1, 2'h0, 16'h5AC3, 4'h1, 1'b1);
	endtask
	task automatic t_max;
		run_dma(2048, 2'h2, 16'h0FF7, 4'h0, 1'b0);
	endtask
	// Scaled copy: start address splice, repeats, dither row step
	task automatic t_scaled;
		logic [31:0] q;
		logic e;
		wr(drs_pkg::ADDR_DITHER_ROW, 32'h0);
		wr(drs_pkg::ADDR_SCALED_CTL, 32'h0000_00FC);
		wr(drs_pkg::ADDR_DMA_BASE, BASE);
		wr(drs_pkg::ADDR_GLOB_MODE, 32'h0000_0002);
		run_cmd({4'h1, 1'b0, 11'h001, 16'h1234}, 4);
		chk("start", {BASE[31:23], 16'h1234, BASE[6:0]}, ra[0]);
		chk("reread", {BASE[31:23], 16'h1234, BASE[6:0]}, ra[2]);
		apb(1'b0, drs_pkg::ADDR_DITHER_ROW, 32'h0, q, e);
		chk("drow", 32'h1000_0000, q & 32'hF800_0000);
	endtask
	task automatic stop_test;
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, cmd_valid} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		cmd = '0;
		lag = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_long();
		t_two();
		t_one();
		t_max();
		t_scaled();
		stop_test();
	end
endmodule
`default_nettype wire
